// >>> include/exu_map.svh
`ifndef EXU_MAP_SVH
`define EXU_MAP_SVH

// Register addresses, control region and physical window
`define EXU_CTRL_TRA     32'hff000020
`define EXU_CTRL_EXP     32'hff000024
`define EXU_CTRL_INT     32'hff000028
`define EXU_PHYS_TRA     32'h1f000020
`define EXU_PHYS_EXP     32'h1f000024
`define EXU_PHYS_INT     32'h1f000028

// Reset values, fixed vector and vector offsets
`define EXU_EXP_POR      12'h000
`define EXU_EXP_MAN      12'h020
`define EXU_RESET_VEC    32'ha0000000
`define EXU_OFS_GEN      32'h00000100
`define EXU_OFS_TLB      32'h00000400

// Event codes
`define EXU_C_MHIT       12'h140
`define EXU_C_BRK        12'h1e0
`define EXU_C_IADR       12'h0e0
`define EXU_C_ITLB       12'h040
`define EXU_C_IPROT      12'h0a0
`define EXU_C_ILL        12'h180
`define EXU_C_SILL       12'h1a0
`define EXU_C_FPUD       12'h800
`define EXU_C_SFPUD      12'h820
`define EXU_C_TRAP       12'h160
`define EXU_C_DADR_R     12'h0e0
`define EXU_C_DADR_W     12'h100
`define EXU_C_DTLB_R     12'h040
`define EXU_C_DTLB_W     12'h060
`define EXU_C_DPROT_R    12'h0a0
`define EXU_C_DPROT_W    12'h0c0
`define EXU_C_FPU        12'h120
`define EXU_C_IPW        12'h080

// Status word bit positions
`define EXU_SR_FD        15
`define EXU_SR_BL        28
`define EXU_SR_RB        29
`define EXU_SR_MD        30

`endif

// >>> include/exu_pkg.sv
package exu_pkg;

  // Event source indexes, in request vector order
  typedef enum logic [4:0] {
    EXU_EV_POR   = 5'h00,
    EXU_EV_MAN   = 5'h01,
    EXU_EV_IMHIT = 5'h02,
    EXU_EV_DMHIT = 5'h03,
    EXU_EV_BRKB  = 5'h04,
    EXU_EV_IADR  = 5'h05,
    EXU_EV_ITLB  = 5'h06,
    EXU_EV_IPROT = 5'h07,
    EXU_EV_ILL   = 5'h08,
    EXU_EV_SILL  = 5'h09,
    EXU_EV_FPUD  = 5'h0a,
    EXU_EV_SFPUD = 5'h0b,
    EXU_EV_TRAP  = 5'h0c,
    EXU_EV_DADR  = 5'h0d,
    EXU_EV_DTLB  = 5'h0e,
    EXU_EV_DPROT = 5'h0f,
    EXU_EV_FPU   = 5'h10,
    EXU_EV_IPW   = 5'h11,
    EXU_EV_BRKA  = 5'h12
  } exu_ev_e;

  localparam int EXU_NEV = 19;

  typedef enum logic [2:0] {
    EXU_ST_IDLE  = 3'b001,
    EXU_ST_ENTRY = 3'b010,
    EXU_ST_BRANCH = 3'b100
  } exu_st_e;

endpackage : exu_pkg

// >>> logic/exu_prio.sv
`timescale 1ns/10ps
`include "exu_map.svh"

// Picks the winning event; request vector is already in rank order
module exu_prio
  import exu_pkg::*;
#(
  parameter int NEV = EXU_NEV
)
(
  input  wire logic [NEV-1:0] i_req,
  input  wire logic           i_write,
  output logic                o_any,
  output logic [4:0]          o_idx,
  output logic [11:0]         o_code,
  output logic                o_fixed,
  output logic                o_reset,
  output logic [31:0]         o_ofs
);

  logic [4:0] idx;

  // Lowest level then lowest order wins
  always_comb
  begin
    idx = 5'h00;
    for (int k = NEV - 1; k >= 0; k--)
    begin
      if (i_req[k])
      begin
        idx = 5'(k); // RL23
      end
    end
  end

  assign o_any   = |i_req;
  assign o_idx   = idx;
  assign o_reset = (idx == EXU_EV_POR) || (idx == EXU_EV_MAN);
  assign o_fixed = idx <= EXU_EV_DMHIT; // RL11 RL13 RL14
  assign o_ofs   = ((idx == EXU_EV_ITLB) || (idx == EXU_EV_DTLB)) ?
                   `EXU_OFS_TLB : `EXU_OFS_GEN; // RL12 RL16 RL19

  always_comb
  begin
    case (idx)
      EXU_EV_POR:   o_code = `EXU_EXP_POR; // RL4
      EXU_EV_MAN:   o_code = `EXU_EXP_MAN;
      EXU_EV_IMHIT: o_code = `EXU_C_MHIT; // RL13
      EXU_EV_DMHIT: o_code = `EXU_C_MHIT; // RL14
      EXU_EV_BRKB:  o_code = `EXU_C_BRK; // RL15
      EXU_EV_IADR:  o_code = `EXU_C_IADR; // RL16
      EXU_EV_ITLB:  o_code = `EXU_C_ITLB;
      EXU_EV_IPROT: o_code = `EXU_C_IPROT;
      EXU_EV_ILL:   o_code = `EXU_C_ILL; // RL17
      EXU_EV_SILL:  o_code = `EXU_C_SILL;
      EXU_EV_FPUD:  o_code = `EXU_C_FPUD;
      EXU_EV_SFPUD: o_code = `EXU_C_SFPUD;
      EXU_EV_TRAP:  o_code = `EXU_C_TRAP; // RL22
      EXU_EV_DADR:  o_code = i_write ? `EXU_C_DADR_W : `EXU_C_DADR_R; // RL18
      EXU_EV_DTLB:  o_code = i_write ? `EXU_C_DTLB_W : `EXU_C_DTLB_R; // RL19
      EXU_EV_DPROT: o_code = i_write ? `EXU_C_DPROT_W : `EXU_C_DPROT_R; // RL20
      EXU_EV_FPU:   o_code = `EXU_C_FPU; // RL21
      EXU_EV_IPW:   o_code = `EXU_C_IPW;
      EXU_EV_BRKA:  o_code = `EXU_C_BRK; // RL22
      default:      o_code = `EXU_EXP_POR;
    endcase
  end

endmodule : exu_prio

// >>> logic/exu_regdec.sv
`timescale 1ns/10ps
`include "exu_map.svh"

// Decodes an address at both its control and physical aliases
module exu_regdec
  import exu_pkg::*;
(
  input  wire logic [31:0] i_addr,
  output logic             o_hit_tra,
  output logic             o_hit_exp,
  output logic             o_hit_int
);

  function automatic logic hit2(input logic [31:0] a,
                                input logic [31:0] c,
                                input logic [31:0] p);
    hit2 = (a == c) || (a == p);
  endfunction : hit2

  assign o_hit_tra = hit2(i_addr, `EXU_CTRL_TRA, `EXU_PHYS_TRA); // RL5
  assign o_hit_exp = hit2(i_addr, `EXU_CTRL_EXP, `EXU_PHYS_EXP); // RL5
  assign o_hit_int = hit2(i_addr, `EXU_CTRL_INT, `EXU_PHYS_INT); // RL5

endmodule : exu_regdec

// >>> logic/exu_entry.sv
`timescale 1ns/10ps
`include "exu_map.svh"

// Notes on behaviour
// RL1: Event register holds 12-bit code; hardware loads, software writes.
// RL2: Interrupt register holds 12-bit code; loaded on interrupt, writable.
// RL3: Trap loads its 8-bit immediate into trap register; writable.
// RL4: Power-on clears exception code; manual reset loads hex 20.
// RL5: Registers decoded at control and physical aliases, 32-bit words.
// RL6: Entry saves program counter, status word and register fifteen.
// RL7: Entry sets block, privilege and bank bits of the status word.
// RL8: Reset events alone clear the fpu disable bit.
// RL9: Entry writes code into bits 11..0 of event register, then branches.
// RL10: Return restores program counter and status, not register fifteen.
// RL11: Reset-category events branch to fixed address a0000000.
// RL12: Other events branch to vector base plus event offset; breakpoints with i_brk_debug set branch to i_debug_base instead.
// RL13: Instruction multiple-hit: level 1 order 3, code 140, fixed vector.
// RL14: Data multiple-hit: level 1 order 4, code 140, fixed vector.
// RL15: Breakpoint before execution: level 2 order 0, code 1e0.
// RL16: Instruction address error, miss, protection at orders 1, 2, 3.
// RL17: Illegal and fpu-disable events: level 2 order 4, offset 100.
// RL18: Data address error order 5, code 0e0 read, 100 write.
// RL19: Data miss order 6, offset 400, code 040 read, 060 write.
// RL20: Data protection order 7, code 0a0 read, 0c0 write.
// RL21: Fpu exception order 8 code 120; page write order 9 code 080.
// RL22: Trap order 4 code 160; breakpoint after execution order 10.
// RL23: Lowest level then lowest order wins among pending events.
module exu_entry
  import exu_pkg::*;
#(
  parameter int NEV = EXU_NEV
)
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  input  wire logic [NEV-1:0] i_ev_req,
  input  wire logic           i_ev_write,
  input  wire logic           i_brk_debug,
  input  wire logic [7:0]     i_trap_imm,
  input  wire logic           i_irq_req,
  input  wire logic [11:0]    i_irq_code,
  input  wire logic [31:0]    i_pc,
  input  wire logic [31:0]    i_status_word,
  input  wire logic [31:0]    i_general_reg_fifteen,
  input  wire logic [31:0]    i_vector_base,
  input  wire logic [31:0]    i_debug_base,
  input  wire logic           i_rte,
  input  wire logic           i_reg_rd,
  input  wire logic           i_reg_wr,
  input  wire logic [31:0]    i_reg_addr,
  input  wire logic [31:0]    i_reg_wdata,
  output logic [31:0]         o_reg_rdata,
  output logic                o_reg_ack,
  output logic                o_entry_busy,
  output logic                o_branch,
  output logic [31:0]         o_branch_addr,
  output logic [31:0]         o_status_word,
  output logic                o_status_load,
  output logic [31:0]         o_saved_program_counter,
  output logic [31:0]         o_saved_status,
  output logic [31:0]         o_saved_general_reg
);

  //////////////////////////////////////////////////////////////////////////
  // Registers
  exu_st_e     st_q;
  logic [11:0] exp_q;
  logic [11:0] int_q;
  logic [7:0]  tra_q;
  logic [31:0] spc_q;
  logic [31:0] ssr_q;
  logic [31:0] sgr_q;
  logic [31:0] sr_q;
  logic        srl_q;
  logic        br_q;
  logic [31:0] bra_q;
  logic [31:0] rdat_q;
  logic        ack_q;
  logic        busy_q;
  logic        isirq_q;
  logic        isrst_q;
  logic        fix_q;
  logic        dbg_q;
  logic [11:0] code_q;
  logic [31:0] ofs_q;

  //////////////////////////////////////////////////////////////////////////
  // Priority and decode
  logic        any_w;
  logic [4:0]  idx_w;
  logic [11:0] code_w;
  logic        fix_w;
  logic        rst_w;
  logic [31:0] ofs_w;
  logic        hit_tra;
  logic        hit_exp;
  logic        hit_int;

  exu_prio #(.NEV(NEV)) u_prio (
    .i_req   (i_ev_req),
    .i_write (i_ev_write),
    .o_any   (any_w),
    .o_idx   (idx_w),
    .o_code  (code_w),
    .o_fixed (fix_w),
    .o_reset (rst_w),
    .o_ofs   (ofs_w)
  );

  exu_regdec u_dec (
    .i_addr    (i_reg_addr),
    .o_hit_tra (hit_tra),
    .o_hit_exp (hit_exp),
    .o_hit_int (hit_int)
  );

  wire idle_w   = st_q == EXU_ST_IDLE;
  wire take_ev  = idle_w && any_w;
  wire take_irq = idle_w && !any_w && i_irq_req;
  wire trap_w   = take_ev && (idx_w == EXU_EV_TRAP);
  wire brk_w    = (idx_w == EXU_EV_BRKB) || (idx_w == EXU_EV_BRKA);
  wire wr_tra   = i_reg_wr && hit_tra;
  wire wr_exp   = i_reg_wr && hit_exp;
  wire wr_int   = i_reg_wr && hit_int;

  // Status word with entry bits applied
  wire [31:0] sr_set = ssr_q | (32'h1 << `EXU_SR_BL)
                     | (32'h1 << `EXU_SR_MD) | (32'h1 << `EXU_SR_RB); // RL7
  wire [31:0] sr_ent = isrst_q ? (sr_set & ~(32'h1 << `EXU_SR_FD))
                               : sr_set; // RL8

  wire [31:0] vec_w = fix_q ? `EXU_RESET_VEC : // RL11
                      dbg_q ? i_debug_base : // RL15
                      i_vector_base + ofs_q; // RL12

  wire [31:0] rd_w = hit_tra ? {24'h0, tra_q} :
                     hit_exp ? {20'h0, exp_q} :
                     hit_int ? {20'h0, int_q} : 32'h0;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_q    <= EXU_ST_IDLE;
      busy_q  <= 1'b0;
      isirq_q <= 1'b0;
      isrst_q <= 1'b0;
      fix_q   <= 1'b0;
      dbg_q   <= 1'b0;
      code_q  <= 12'h0;
      ofs_q   <= 32'h0;
    end
    else
    begin
      case (st_q)
        EXU_ST_IDLE:
        begin
          if (take_ev || take_irq)
          begin
            st_q    <= EXU_ST_ENTRY;
            busy_q  <= 1'b1;
            isirq_q <= take_irq;
            isrst_q <= take_ev && rst_w;
            fix_q   <= take_ev && fix_w;
            dbg_q   <= take_ev && brk_w && i_brk_debug;
            code_q  <= take_ev ? code_w : i_irq_code;
            ofs_q   <= ofs_w;
          end
        end
        EXU_ST_ENTRY:  st_q <= EXU_ST_BRANCH;
        EXU_ST_BRANCH:
        begin
          st_q   <= EXU_ST_IDLE;
          busy_q <= 1'b0;
        end
        default:
        begin
          st_q   <= EXU_ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State save and branch
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      spc_q <= 32'h0;
      ssr_q <= 32'h0;
      sgr_q <= 32'h0;
      sr_q  <= 32'h0;
      srl_q <= 1'b0;
      br_q  <= 1'b0;
      bra_q <= 32'h0;
    end
    else
    begin
      srl_q <= 1'b0;
      br_q  <= 1'b0;
      if (take_ev || take_irq)
      begin
        spc_q <= i_pc; // RL6
        ssr_q <= i_status_word; // RL6
        sgr_q <= i_general_reg_fifteen; // RL6
      end
      if (st_q == EXU_ST_ENTRY)
      begin
        sr_q  <= sr_ent; // RL7
        srl_q <= 1'b1;
      end
      else if (st_q == EXU_ST_BRANCH)
      begin
        br_q  <= 1'b1; // RL9
        bra_q <= vec_w;
      end
      else if (i_rte)
      begin
        sr_q  <= ssr_q; // RL10
        srl_q <= 1'b1;
        br_q  <= 1'b1;
        bra_q <= spc_q; // RL10
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event registers; hardware load wins over a same-cycle write
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      exp_q <= `EXU_EXP_POR; // RL4
      int_q <= 12'h0;
      tra_q <= 8'h0;
    end
    else
    begin
      if (st_q == EXU_ST_ENTRY && !isirq_q)
        exp_q <= code_q; // RL1 RL9
      else if (wr_exp)
        exp_q <= i_reg_wdata[11:0]; // RL1
      if (st_q == EXU_ST_ENTRY && isirq_q)
        int_q <= code_q; // RL2 RL9
      else if (wr_int)
        int_q <= i_reg_wdata[11:0]; // RL2
      if (trap_w)
        tra_q <= i_trap_imm; // RL3
      else if (wr_tra)
        tra_q <= i_reg_wdata[7:0]; // RL3
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rdat_q <= 32'h0;
      ack_q  <= 1'b0;
    end
    else
    begin
      ack_q  <= i_reg_rd || i_reg_wr;
      rdat_q <= i_reg_rd ? rd_w : 32'h0; // RL5
    end
  end

  assign o_reg_rdata             = rdat_q;
  assign o_reg_ack               = ack_q;
  assign o_entry_busy            = busy_q;
  assign o_branch                = br_q;
  assign o_branch_addr           = bra_q;
  assign o_status_word           = sr_q;
  assign o_status_load           = srl_q;
  assign o_saved_program_counter = spc_q;
  assign o_saved_status          = ssr_q;
  assign o_saved_general_reg     = sgr_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_entry_start;
    idle_w && any_w;
  endsequence

  sequence s_branch_out;
    ##3 br_q;
  endsequence

  entry_branch_a: assert property ( // RL9
    @(posedge i_ref_clk) disable iff (i_rst)
    s_entry_start |-> s_branch_out)
    else $error("branch not three cycles after entry");

  reset_vector_a: assert property ( // RL11
    @(posedge i_ref_clk) disable iff (i_rst)
    (idle_w && any_w && fix_w) |-> ##3 (bra_q == `EXU_RESET_VEC))
    else $error("reset class vector wrong");

  save_pc_a: assert property ( // RL6
    @(posedge i_ref_clk) disable iff (i_rst)
    (take_ev || take_irq) |=> (spc_q == $past(i_pc)))
    else $error("program counter not saved");

  status_bits_a: assert property ( // RL7
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_q == EXU_ST_ENTRY) |=> (sr_q[`EXU_SR_BL] && sr_q[`EXU_SR_MD]
                              && sr_q[`EXU_SR_RB] && srl_q))
    else $error("entry status bits not set");

  fpu_clear_a: assert property ( // RL8
    @(posedge i_ref_clk) disable iff (i_rst)
    (idle_w && any_w && rst_w) |-> ##2 !sr_q[`EXU_SR_FD])
    else $error("fpu disable not cleared on reset");

  exp_code_a: assert property ( // RL1
    @(posedge i_ref_clk) disable iff (i_rst)
    (take_ev) |-> ##2 (exp_q == $past(code_w, 2)))
    else $error("event code not loaded");

  trap_imm_a: assert property ( // RL3
    @(posedge i_ref_clk) disable iff (i_rst)
    trap_w |=> (tra_q == $past(i_trap_imm)))
    else $error("trap immediate not captured");

  rte_restore_a: assert property ( // RL10
    @(posedge i_ref_clk) disable iff (i_rst)
    (idle_w && i_rte) |=> (sr_q == ssr_q) && (bra_q == spc_q) && br_q)
    else $error("return did not restore");

endmodule : exu_entry

// >>> dv/exu_pipe_model.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Pipeline side: follows branches and status loads
module exu_pipe_model
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_branch,
  input  wire logic [31:0] i_branch_addr,
  input  wire logic        i_status_load,
  input  wire logic [31:0] i_status_word,
  output logic [31:0]      o_pc,
  output logic [31:0]      o_status_word,
  output logic [31:0]      o_general_reg_fifteen
);
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_pc                  <= 32'h0c001000;
      o_status_word         <= 32'h00008000;
      o_general_reg_fifteen <= 32'h0c00fff0;
    end
    else
    begin
      if (i_branch)
      begin
        o_pc                  <= i_branch_addr;
        o_general_reg_fifteen <= o_general_reg_fifteen - 32'h10;
      end
      if (i_status_load)
        o_status_word <= i_status_word;
    end
  end
endmodule : exu_pipe_model

// >>> dv/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module testbench
  import exu_pkg::*;
;

  typedef struct {
    logic [4:0]  idx;
    logic        wr;
    logic        dbg;
    logic [11:0] code;
    logic [31:0] ofs;
    logic        fix;
  } exu_row_s;

  localparam logic [31:0] VB = 32'h9c080000;
  localparam logic [31:0] DB = 32'h8c000000;

  logic               i_ref_clk, i_rst, i_ev_write, i_brk_debug;
  logic               i_irq_req, i_rte, i_reg_rd, i_reg_wr;
  logic [EXU_NEV-1:0] i_ev_req;
  logic [11:0]        i_irq_code;
  logic [31:0]        i_reg_addr, i_reg_wdata, pipe_pc, pipe_sr, pipe_r15;
  logic [31:0]        o_reg_rdata, o_branch_addr, o_status_word;
  logic [31:0]        o_saved_program_counter, o_saved_status;
  logic [31:0]        o_saved_general_reg;
  logic               o_reg_ack, o_entry_busy, o_branch, o_status_load;
  int                 fails = 0;
  int                 total_checks = 0;
  logic [EXU_NEV-1:0] pm [4] = '{19'h20120, 19'h01004, 19'h00018, 19'h00006};
  logic [11:0]        pcode [4] = '{12'h0e0, 12'h140, 12'h140, 12'h020};

  exu_row_s rows [23] = '{
    '{0, 0, 0, 12'h000, 0, 1}, '{1, 0, 0, 12'h020, 0, 1},
    '{2, 0, 0, 12'h140, 0, 1}, '{3, 0, 0, 12'h140, 0, 1},
    '{4, 0, 0, 12'h1e0, 32'h100, 0}, '{4, 0, 1, 12'h1e0, 0, 0},
    '{5, 0, 0, 12'h0e0, 32'h100, 0}, '{6, 0, 0, 12'h040, 32'h400, 0},
    '{7, 0, 0, 12'h0a0, 32'h100, 0}, '{8, 0, 0, 12'h180, 32'h100, 0},
    '{9, 0, 0, 12'h1a0, 32'h100, 0}, '{10, 0, 0, 12'h800, 32'h100, 0},
    '{11, 0, 0, 12'h820, 32'h100, 0}, '{12, 0, 0, 12'h160, 32'h100, 0},
    '{13, 0, 0, 12'h0e0, 32'h100, 0}, '{13, 1, 0, 12'h100, 32'h100, 0},
    '{14, 0, 0, 12'h040, 32'h400, 0}, '{14, 1, 0, 12'h060, 32'h400, 0},
    '{15, 0, 0, 12'h0a0, 32'h100, 0}, '{15, 1, 0, 12'h0c0, 32'h100, 0},
    '{16, 0, 0, 12'h120, 32'h100, 0}, '{17, 0, 0, 12'h080, 32'h100, 0},
    '{18, 0, 1, 12'h1e0, 0, 0}
  };

  //////////////////////////////////////////////////////////////////////////////
  // Design and pipeline model
  exu_entry #(.NEV(EXU_NEV)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ev_req(i_ev_req),
    .i_ev_write(i_ev_write), .i_brk_debug(i_brk_debug),
    .i_trap_imm(8'hc3), .i_irq_req(i_irq_req), .i_irq_code(i_irq_code),
    .i_pc(pipe_pc), .i_status_word(pipe_sr),
    .i_general_reg_fifteen(pipe_r15), .i_vector_base(VB),
    .i_debug_base(DB), .i_rte(i_rte), .i_reg_rd(i_reg_rd),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_ack(o_reg_ack), .o_entry_busy(o_entry_busy),
    .o_branch(o_branch), .o_branch_addr(o_branch_addr),
    .o_status_word(o_status_word), .o_status_load(o_status_load),
    .o_saved_program_counter(o_saved_program_counter),
    .o_saved_status(o_saved_status),
    .o_saved_general_reg(o_saved_general_reg)
  );

  exu_pipe_model pipe_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_branch(o_branch),
    .i_branch_addr(o_branch_addr), .i_status_load(o_status_load),
    .i_status_word(o_status_word), .o_pc(pipe_pc),
    .o_status_word(pipe_sr), .o_general_reg_fifteen(pipe_r15)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic wait_br(output logic [31:0] sr_g, ba_g);
    int n;
    n = 0;
    sr_g = 'x;
    #1;
    if (o_status_load === 1'b1)
      sr_g = o_status_word;
    while (o_branch !== 1'b1 && n < 10)
    begin
      @(posedge i_ref_clk);
      #1;
      if (o_status_load === 1'b1)
        sr_g = o_status_word;
      n++;
    end
    ba_g = o_branch_addr;
    if (o_branch !== 1'b1)
    begin
      fails++;
      summarize();
    end
  endtask : wait_br

  task automatic fire(input logic [EXU_NEV-1:0] m, input logic w, d, irq,
                      output logic [31:0] sr_g, ba_g);
    @(posedge i_ref_clk);
    i_ev_req    <= m;
    i_ev_write  <= w;
    i_brk_debug <= d;
    i_irq_req   <= irq;
    @(posedge i_ref_clk);
    i_ev_req  <= '0;
    i_irq_req <= 1'b0;
    wait_br(sr_g, ba_g);
  endtask : fire

  task automatic acc(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_reg_rd    <= !w;
    i_reg_wr    <= w;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    i_reg_wr <= 1'b0;
    #1;
    while (o_reg_ack !== 1'b1 && n < 5)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    q = o_reg_rdata;
    if (o_reg_ack !== 1'b1)
    begin
      fails++;
      summarize();
    end
  endtask : acc

  task automatic rte_chk(input logic [31:0] pc0, sr0, r0);
    logic [31:0] sr_g, ba_g;
    @(posedge i_ref_clk);
    i_rte <= 1'b1;
    @(posedge i_ref_clk);
    i_rte <= 1'b0;
    wait_br(sr_g, ba_g);
    `CHK(ba_g, pc0)
    `CHK(sr_g, sr0)
    `CHK(o_saved_general_reg, r0)
    @(posedge i_ref_clk);
    #1;
  endtask : rte_chk

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    exu_row_s    r;
    logic [EXU_NEV-1:0] m;
    logic [31:0] q, sr_g, ba_g, pc0, sr0, r0, ea;
    int          n;
    i_rst = 1'b1;
    i_ev_req = '0;
    i_ev_write = 1'b0;
    i_brk_debug = 1'b0;
    i_irq_req = 1'b0;
    i_irq_code = 12'h0;
    i_rte = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_addr = 32'h0;
    i_reg_wdata = 32'h0;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b0, 32'hff000020 + 32'(4 * i), '0, q);
      `CHK(q, 32'h0)
    end
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, 32'h1f000020 + 32'(4 * i), '1, q);
      acc(1'b0, 32'hff000020 + 32'(4 * i), '0, q);
      `CHK(q, (i == 0) ? 32'hff : 32'hfff)
    end
    foreach (rows[k])
    begin
      r = rows[k];
      pc0 = pipe_pc;
      sr0 = pipe_sr;
      r0 = pipe_r15;
      m = '0;
      m[r.idx] = 1'b1;
      fire(m, r.wr, r.dbg, 1'b0, sr_g, ba_g);
      ea = r.fix ? 32'ha0000000 : (r.dbg ? DB : VB + r.ofs);
      `CHK(ba_g, ea)
      q = sr0 | 32'h70000000;
      if (r.idx < 5'd2)
        q[15] = 1'b0;
      `CHK(sr_g, q)
      `CHK(o_saved_program_counter, pc0)
      `CHK(o_saved_status, sr0)
      `CHK(o_saved_general_reg, r0)
      acc(1'b0, (k % 2) ? 32'h1f000024 : 32'hff000024, '0, q);
      `CHK(q, {20'h0, r.code})
      if (r.idx == 5'd12)
      begin
        acc(1'b0, 32'hff000020, '0, q);
        `CHK(q, 32'h000000c3)
      end
      rte_chk(pc0, sr0, r0);
    end
    for (int i = 0; i < 4; i++)
    begin
      fire(pm[i], 1'b0, 1'b0, 1'b0, sr_g, ba_g);
      `CHK(ba_g, (i == 0) ? VB + 32'h100 : 32'ha0000000)
      acc(1'b0, 32'hff000024, '0, q);
      `CHK(q, {20'h0, pcode[i]})
    end
    @(posedge i_ref_clk);
    i_irq_code <= 12'h3c0;
    fire('0, 1'b0, 1'b0, 1'b1, sr_g, ba_g);
    acc(1'b0, 32'hff000028, '0, q);
    `CHK(q, 32'h3c0)
    acc(1'b0, 32'h1f000024, '0, q);
    `CHK(q, 32'h020)
    fire(19'h00100, 1'b0, 1'b0, 1'b1, sr_g, ba_g);
    acc(1'b0, 32'hff000024, '0, q);
    `CHK(q, 32'h180)
    acc(1'b0, 32'hff000028, '0, q);
    `CHK(q, 32'h3c0)
    @(posedge i_ref_clk);
    i_ev_req <= 19'h00100;
    @(posedge i_ref_clk);
    i_ev_req <= 19'h00020;
    #1;
    `CHK(o_entry_busy, 1'b1)
    repeat (2) @(posedge i_ref_clk);
    i_ev_req <= '0;
    wait_br(sr_g, ba_g);
    `CHK(o_entry_busy, 1'b0)
    n = 0;
    repeat (6)
    begin
      @(posedge i_ref_clk);
      #1;
      n += int'(o_branch === 1'b1);
    end
    `CHK(n, 0)
    acc(1'b0, 32'hff000024, '0, q);
    `CHK(q, 32'h180)
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    `CHK(o_saved_status, 32'h0)
    acc(1'b0, 32'h1f000024, '0, q);
    `CHK(q, 32'h0)
    summarize();
  end
endmodule : testbench
